// >>> logic/qsf_regs.vh
// constants for the quad serial flash command interface
`ifndef QSF_REGS_VH
`define QSF_REGS_VH
// ----------------------------------------------------------------
// command codes (arbitrary encodings; the table gives none)
// ----------------------------------------------------------------
`define QSF_CMD_QUAD_EN 8'h38
`define QSF_CMD_QUAD_EXIT 8'hff
`define QSF_CMD_WRSR 8'h01
`define QSF_CMD_RDSR 8'h05
// ----------------------------------------------------------------
// geometry
// ----------------------------------------------------------------
`define QSF_SECTOR_BYTES 4096
`define QSF_BLK32_BYTES 32768
`define QSF_BLK64_BYTES 65536
`define QSF_PAGE_BYTES 256
`define QSF_SECID_BYTES 2048
`define QSF_UID_BITS 128
// ----------------------------------------------------------------
// status fields and reset values
// ----------------------------------------------------------------
`define QSF_ST_BUSY 0
`define QSF_ST_BP_LO 2
`define QSF_ST_BP_HI 5
`define QSF_ST_BPL 7
`define QSF_ST_RESET 8'h00
`endif

// >>> logic/qsf_sync.v
// two flip-flop synchroniser for one pin
`timescale 1ns/1ps
module qsf_sync #(
  parameter RST_VAL = 1'b0
) (
  // clock and reset
  input wire clk_i,
  input wire rst_n_i,
  // pin and synchronised level
  input wire d_i,
  output wire q_o
);
  reg meta_r;
  reg sync_r;

  // first stage is read only by the second
  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      meta_r <= RST_VAL;
      sync_r <= RST_VAL;
    end
    else
    begin
      meta_r <= d_i;
      sync_r <= meta_r;
    end
  end

  assign q_o = sync_r;
endmodule // qsf_sync

// >>> logic/qsf_core.v
// device-side serial command front end of the quad flash interface
`timescale 1ns/1ps
`include "qsf_regs.vh"
module qsf_core (
  // clock and reset
  input wire clk_i,
  input wire rst_n_i,
  // serial pins from the host
  input wire sck_i,
  input wire cs_n_i,
  input wire [3:0] quad_data_lines_i,
  output reg [3:0] quad_data_lines_o,
  output reg [3:0] quad_data_lines_oe_o,
  input wire protect_n_i,
  input wire pause_n_i,
  // configuration and status
  input wire protect_pin_enable_i,
  input wire io_config_bit_i,
  input wire busy_i,
  output reg quad_mode_o,
  output reg [7:0] status_o,
  // received command stream
  output reg [7:0] rx_byte_o,
  output reg rx_valid_o,
  output reg cmd_start_o,
  // read data to send
  input wire [7:0] tx_byte_i,
  output wire tx_ready_o
);
  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  wire sck_s;
  wire cs_n_s;
  wire pause_n_s;
  wire protect_n_s;
  wire [3:0] dat_s;
  qsf_sync #(.RST_VAL(1'b0)) u_sck (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .d_i(sck_i), .q_o(sck_s));
  qsf_sync #(.RST_VAL(1'b1)) u_cs (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .d_i(cs_n_i), .q_o(cs_n_s));
  qsf_sync #(.RST_VAL(1'b1)) u_pause (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .d_i(pause_n_i), .q_o(pause_n_s));
  qsf_sync #(.RST_VAL(1'b1)) u_prot (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .d_i(protect_n_i), .q_o(protect_n_s));
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : g_dat
      qsf_sync #(.RST_VAL(1'b0)) u_d (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .d_i(quad_data_lines_i[g]), .q_o(dat_s[g]));
    end
  endgenerate

  // ----------------------------------------------------------------
  // edge detection
  // ----------------------------------------------------------------
  reg sck_d_r;
  reg cs_n_d_r;
  reg hold_r;
  wire sck_rise = sck_s & ~sck_d_r;
  wire sck_fall = ~sck_s & sck_d_r;
  wire cs_fall = cs_n_d_r & ~cs_n_s;
  wire sel = ~cs_n_s;
  // pause only in single-bit mode; quad mode ignores the pin
  wire pause_act = hold_r & ~quad_mode_o;
  wire rise_ok = sel & sck_rise & ~pause_act;
  wire fall_ok = sel & sck_fall & ~pause_act;

  // ----------------------------------------------------------------
  // shifter state
  // ----------------------------------------------------------------
  reg [7:0] sh_r;
  reg [2:0] cnt_r;
  reg first_r;
  reg is_cmd_r;
  reg wrsr_r;
  reg rdsr_r;
  reg [7:0] tx_sh_r;
  reg [2:0] tx_cnt_r;
  reg tx_ready_r;
  wire [2:0] step = quad_mode_o ? 3'd4 : 3'd1;
  wire [7:0] sh_nxt = quad_mode_o ? {sh_r[3:0], dat_s} :
    {sh_r[6:0], dat_s[0]};
  wire [2:0] cnt_nxt = cnt_r + step;
  wire byte_done = quad_mode_o ? (cnt_r == 3'd4) : (cnt_r == 3'd7);
  // protection lock of status writes; io config overrides the pin
  wire prot_lock = ~protect_n_s & ~io_config_bit_i & protect_pin_enable_i &
    status_o[`QSF_ST_BPL];
  assign tx_ready_o = tx_ready_r;

  // pause starts and ends only while the serial clock is low; deselect ends it at any clock level
  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      hold_r <= 1'b0;
    else if (!sel)
      hold_r <= 1'b0;
    else if (!sck_s)
      hold_r <= ~pause_n_s;
  end

  // ----------------------------------------------------------------
  // receive path: sample on rising serial clock
  // ----------------------------------------------------------------
  // the reset pin drives rst_n_i, so every flop here clears on it
  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sck_d_r <= 1'b0;
      cs_n_d_r <= 1'b1;
      sh_r <= 8'h00;
      cnt_r <= 3'd0;
      first_r <= 1'b0;
      is_cmd_r <= 1'b0;
      wrsr_r <= 1'b0;
      rdsr_r <= 1'b0;
      quad_mode_o <= 1'b0;
      status_o <= `QSF_ST_RESET;
      rx_byte_o <= 8'h00;
      rx_valid_o <= 1'b0;
      cmd_start_o <= 1'b0;
    end
    else
    begin
      sck_d_r <= sck_s;
      cs_n_d_r <= cs_n_s;
      rx_valid_o <= 1'b0;
      cmd_start_o <= 1'b0;
      // a suspended program or erase drops busy so the array can be read
      status_o[`QSF_ST_BUSY] <= busy_i;
      if (cs_fall)
      begin
        // only a falling select opens a command; clock level is free
        cnt_r <= 3'd0;
        is_cmd_r <= 1'b1;
        wrsr_r <= 1'b0;
        rdsr_r <= 1'b0;
        // only a clock idling high (mode 3) has a fall to skip first
        first_r <= sck_s;
        cmd_start_o <= 1'b1;
      end
      else if (rise_ok && !first_r)
      begin
        sh_r <= sh_nxt;
        cnt_r <= byte_done ? 3'd0 : cnt_nxt;
        if (byte_done)
        begin
          rx_byte_o <= sh_nxt;
          rx_valid_o <= 1'b1;
          is_cmd_r <= 1'b0;
          if (is_cmd_r)
          begin
            wrsr_r <= (sh_nxt == `QSF_CMD_WRSR);
            rdsr_r <= (sh_nxt == `QSF_CMD_RDSR);
            if (sh_nxt == `QSF_CMD_QUAD_EN)
              quad_mode_o <= 1'b1;
            else if (sh_nxt == `QSF_CMD_QUAD_EXIT)
              quad_mode_o <= 1'b0;
          end
          else if (wrsr_r && !prot_lock)
          begin
            // busy bit stays hardware owned; protection bits update
            status_o[7:1] <= sh_nxt[7:1];
            wrsr_r <= 1'b0;
          end
        end
      end
      // mode 3 idles the clock high: bits start after its first fall
      if (!cs_fall && sel && first_r && sck_fall)
        first_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // transmit path: change outputs on falling serial clock
  // ----------------------------------------------------------------
  wire [7:0] tx_src = rdsr_r ? status_o : tx_byte_i;
  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      tx_sh_r <= 8'h00;
      tx_cnt_r <= 3'd0;
      tx_ready_r <= 1'b0;
      quad_data_lines_o <= 4'h0;
      quad_data_lines_oe_o <= 4'h0;
    end
    else
    begin
      tx_ready_r <= 1'b0;
      if (!sel)
      begin
        quad_data_lines_oe_o <= 4'h0;
        tx_cnt_r <= 3'd0;
      end
      else if (fall_ok && !is_cmd_r)
      begin
        if (tx_cnt_r == 3'd0)
        begin
          tx_sh_r <= quad_mode_o ? {tx_src[3:0], 4'h0} :
            {tx_src[6:0], 1'b0};
          quad_data_lines_o <= quad_mode_o ? tx_src[7:4] :
            {2'b00, tx_src[7], 1'b0};
          // one ready per byte keeps a linear burst running
          tx_ready_r <= 1'b1;
        end
        else
        begin
          tx_sh_r <= quad_mode_o ? {tx_sh_r[3:0], 4'h0} :
            {tx_sh_r[6:0], 1'b0};
          quad_data_lines_o <= quad_mode_o ? tx_sh_r[7:4] :
            {2'b00, tx_sh_r[7], 1'b0};
        end
        // quad drives all four lines, single drives only line 1
        quad_data_lines_oe_o <= quad_mode_o ? 4'hf : 4'h2;
        tx_cnt_r <= (quad_mode_o ? (tx_cnt_r == 3'd4) :
          (tx_cnt_r == 3'd7)) ? 3'd0 : tx_cnt_r + step;
      end
    end
  end
endmodule // qsf_core

// >>> bench/qsf_core_checker.sv
// port assertions for the quad flash serial front end
`timescale 1ns/1ps
`include "qsf_regs.vh"
module qsf_core_checker (
  // clock and reset
  input wire clk_i,
  input wire rst_n_i,
  // pins
  input wire sck_i,
  input wire cs_n_i,
  input wire pause_n_i,
  input wire [3:0] quad_data_lines_o,
  input wire [3:0] quad_data_lines_oe_o,
  // status and stream
  input wire quad_mode_o,
  input wire [7:0] rx_byte_o,
  input wire rx_valid_o,
  input wire cmd_start_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  AST_DESEL_OE: assert property (cs_n_i [*5] |-> quad_data_lines_oe_o == 4'h0)
    else $error("outputs driven while deselected");
  AST_CS_START: assert property ($fell(cs_n_i) |-> ##3 cmd_start_o)
    else $error("no command start after select");
  AST_RST_SINGLE: assert property (!$past(rst_n_i) |-> !quad_mode_o && quad_data_lines_oe_o == 4'h0)
    else $error("not single mode after reset");
  AST_QUAD_OE: assert property (quad_mode_o && |quad_data_lines_oe_o |-> quad_data_lines_oe_o == 4'hf)
    else $error("quad mode not driving four lines");
  // sync lag means a falling edge shows two cycles late at the pins
  AST_OUT_FALL: assert property ($changed(quad_data_lines_o) && !cs_n_i |-> !$past(sck_i, 2))
    else $error("output changed off a falling edge");
  AST_QUAD_CMD: assert property (rx_valid_o && rx_byte_o == `QSF_CMD_QUAD_EN |-> ##[1:3] quad_mode_o)
    else $error("quad enable not taken");
  AST_PAUSE: assert property ((!pause_n_i && !quad_mode_o) [*8] |-> !rx_valid_o)
    else $error("byte taken while paused");
  AST_RX_PULSE: assert property (rx_valid_o |=> !rx_valid_o)
    else $error("byte strobe longer than a cycle");
endmodule // qsf_core_checker

// >>> bench/qsf_host_model.sv
// host master model: serial clock, select and data lines
`timescale 1ns/1ps
module qsf_host_model (
  // clock
  input wire clk_i,
  // pins
  output reg sck_o = 1'b0,
  output reg cs_n_o = 1'b1,
  output reg [3:0] dq_o = 4'h0,
  input wire [3:0] dq_i
);
  // select; idle level of the serial clock picks mode 0 or 3
  task sel(input m3);
    begin
      @(posedge clk_i) sck_o <= m3;
      @(posedge clk_i) cs_n_o <= 1'b0;
      repeat (6) @(posedge clk_i);
    end
  endtask
  // select held low for the whole frame, raised before the clock idles
  task desel(input m3);
    begin
      @(posedge clk_i) cs_n_o <= 1'b1;
      @(posedge clk_i) sck_o <= m3;
      dq_o <= ~dq_o;
      repeat (8) @(posedge clk_i);
    end
  endtask
  // one byte out and in, msb or high nibble first, six clocks a half
  task xfer(input [7:0] b, input q, output [7:0] r);
    integer i;
    begin
      for (i = 0; i < (q ? 2 : 8); i = i + 1)
      begin
        @(posedge clk_i);
        sck_o <= 1'b0;
        dq_o <= q ? b[7-4*i -: 4] : {3'h0, b[7-i]};
        repeat (6) @(posedge clk_i);
        sck_o <= 1'b1;
        r = q ? {r[3:0], dq_i} : {r[6:0], dq_i[1]};
        repeat (5) @(posedge clk_i);
      end
    end
  endtask
endmodule // qsf_host_model

// >>> bench/tb.sv
// self-checking bench for the quad flash serial front end
`timescale 1ns/1ps
module tb;
  reg clk_i = 1'b0;
  reg rst_n_i = 1'b0;
  reg prot_n = 1'b1;
  reg pause_n = 1'b1;
  reg pe = 1'b0;
  reg io_config_bit = 1'b0;
  reg busy = 1'b0;
  reg [7:0] tx = 8'h00;
  reg [31:0] seed = 32'd31882;
  reg [7:0] rxq [$];
  reg [7:0] r;
  integer errors = 0;
  integer tests_run = 0;
  integer txn = 0;
  integer i;
  wire sck, cs_n, qm, rxv, cst, txr;
  wire [3:0] hdq, dq, q, oe;
  wire [7:0] st, rxb;
  always #2 clk_i = ~clk_i;
  // wire level: the device where it drives, the host elsewhere
  assign dq = (oe & q) | (~oe & hdq);
  qsf_host_model HOST (.clk_i(clk_i), .sck_o(sck), .cs_n_o(cs_n),
    .dq_o(hdq), .dq_i(dq));
  qsf_core DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .sck_i(sck),
    .cs_n_i(cs_n), .quad_data_lines_i(dq), .quad_data_lines_o(q),
    .quad_data_lines_oe_o(oe), .protect_n_i(prot_n), .pause_n_i(pause_n),
    .protect_pin_enable_i(pe), .io_config_bit_i(io_config_bit), .busy_i(busy),
    .quad_mode_o(qm), .status_o(st), .rx_byte_o(rxb), .rx_valid_o(rxv),
    .cmd_start_o(cst), .tx_byte_i(tx), .tx_ready_o(txr));
  // received bytes queue up; read-data requests are counted
  always @(posedge clk_i)
  begin
    if (rxv)
      rxq.push_back(rxb);
    if (txr)
      txn <= txn + 1;
  end
  // xorshift; bytes kept clear of the special command codes
  function [7:0] rnd();
    begin
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      rnd = {2'b10, seed[5:0]};
    end
  endfunction
  task chk(input [15:0] got, input [15:0] exp);
    begin
      tests_run = tests_run + 1;
      if (got !== exp)
      begin
        errors = errors + 1;
        $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task frame(input m3, input qd, input two, input [7:0] c, input [7:0] d);
    begin
      HOST.sel(m3);
      HOST.xfer(c, qd, r);
      if (two)
        HOST.xfer(d, qd, r);
      HOST.desel(m3);
    end
  endtask
  // random frame: command and data in, read byte out
  task sendchk(input m3, input qd);
    reg [7:0] c, d, x;
    integer n;
    begin
      c = rnd();
      d = rnd();
      x = rnd();
      n = txn;
      @(posedge clk_i) tx <= x;
      frame(m3, qd, 1'b1, c, d);
      chk(r, x);
      chk(rxq.pop_front(), c);
      // quad shares one wire: read nibbles own it after the command
      chk(rxq.pop_front(), qd ? x : d);
      chk(16'(txn - n), 16'h1);
    end
  endtask
  task conclude;
    begin
      $display("errors %0d tests_run %0d", errors, tests_run);
      if (errors == 0 && tests_run > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  // a hang is cut short here
  initial
  begin
    #100000;
    errors = errors + 1;
    conclude;
  end
  initial
  begin
    repeat (5) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    chk({qm, oe, st}, 16'h0);
    for (i = 0; i < 6; i = i + 1)
      sendchk(i[0], 1'b0);
    // clocking while deselected must be ignored
    HOST.xfer(8'h38, 1'b0, r);
    HOST.desel(1'b0);
    chk(16'(rxq.size()), 16'h0);
    // edges under pause are lost, later ones count
    HOST.sel(1'b0);
    pause_n <= 1'b0;
    HOST.xfer(8'h38, 1'b0, r);
    pause_n <= 1'b1;
    HOST.xfer(8'h99, 1'b0, r);
    HOST.desel(1'b0);
    chk({qm, rxq.pop_front()}, 16'h99);
    frame(1'b0, 1'b0, 1'b1, 8'h01, 8'h80);
    prot_n <= 1'b0;
    pe <= 1'b1;
    frame(1'b0, 1'b0, 1'b1, 8'h01, 8'h3c);
    chk(st, 16'h80);
    io_config_bit <= 1'b1;
    busy <= 1'b1;
    frame(1'b0, 1'b0, 1'b1, 8'h01, 8'h3c);
    frame(1'b0, 1'b0, 1'b1, 8'h05, 8'h00);
    chk({st, r}, 16'h3d3d);
    busy <= 1'b0;
    frame(1'b0, 1'b0, 1'b0, 8'h38, 8'h00);
    chk(qm, 16'h1);
    rxq.delete();
    for (i = 0; i < 3; i = i + 1)
      sendchk(i[0], 1'b1);
    // reset in mid-frame aborts and returns to single mode
    HOST.sel(1'b0);
    rst_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    HOST.desel(1'b0);
    chk({qm, oe, st}, 16'h0);
    // quad entry again, then the exit command back to single lines
    frame(1'b0, 1'b0, 1'b0, 8'h38, 8'h00);
    frame(1'b1, 1'b1, 1'b0, 8'hff, 8'h00);
    chk(qm, 16'h0);
    conclude;
  end
endmodule // tb
bind qsf_core qsf_core_checker CHK (.clk_i(clk_i), .rst_n_i(rst_n_i),
  .sck_i(sck_i), .cs_n_i(cs_n_i), .pause_n_i(pause_n_i),
  .quad_data_lines_o(quad_data_lines_o),
  .quad_data_lines_oe_o(quad_data_lines_oe_o), .quad_mode_o(quad_mode_o),
  .rx_byte_o(rx_byte_o), .rx_valid_o(rx_valid_o),
  .cmd_start_o(cmd_start_o));
